// ### rtl/ext_cpu_pkg.sv
// Shared constants and types for the extension instruction unit
package ext_cpu_pkg;
   // Flag register bit positions
   localparam int FLAG_SIGN      = 7;
   localparam int FLAG_ZERO      = 6;
   localparam int FLAG_HALF      = 4;
   localparam int FLAG_PARITY    = 2;
   localparam int FLAG_SUBTRACT  = 1;
   localparam int FLAG_CARRY     = 0;
   // Reset values and upper port address byte
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [15:0] SP_RESET  = 16'h0000;
   localparam logic [7:0]  IV_RESET  = 8'h00;
   localparam logic [7:0]  RC_RESET  = 8'h00;
   localparam logic [7:0]  PORT_HIGH = 8'h00;
   // Register pair selectors
   typedef enum logic [1:0] {
      PAIR_COUNTER = 2'h0,
      PAIR_DATA    = 2'h1,
      PAIR_MEMPTR  = 2'h2,
      PAIR_STACK   = 2'h3
   } pair_sel_t;
   // Extension operations
   typedef enum logic [3:0] {
      OP_NONE       = 4'h0,
      OP_SLEEP      = 4'h1,
      OP_MULTIPLY   = 4'h2,
      OP_OUT_INC    = 4'h3,
      OP_OUT_INC_RP = 4'h4,
      OP_OUT_DEC    = 4'h5,
      OP_OUT_DEC_RP = 4'h6,
      OP_PORT_TEST  = 4'h7,
      OP_TEST_REG   = 4'h8,
      OP_TEST_IMM   = 4'h9,
      OP_TEST_MEM   = 4'ha,
      OP_PORT_IN    = 4'hb,
      OP_PORT_OUT   = 4'hc,
      OP_EXCHANGE   = 4'hd
   } ext_op_t;
   // Instruction request from the fetch side
   typedef struct packed {
      ext_op_t     op;
      pair_sel_t   pair;
      logic [2:0]  reg_sel;
      logic [7:0]  operand;
   } ext_req_t;
   // External bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        mem_rd;
      logic        io_rd;
      logic        io_wr;
   } bus_req_t;
   // Execution states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_MEMRD  = 3'b001,
      ST_IOACC  = 3'b011,
      ST_FINISH = 3'b010,
      ST_SLEEP  = 3'b110
   } exec_state_t;
endpackage

// ### rtl/extended_cpu_instructions.sv
// Execution unit for the extension instructions and the CPU register file
`timescale 1ns/1ns
module extended_cpu_instructions (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   input  wire logic                  req_valid,   // Start an instruction
   input  wire ext_cpu_pkg::ext_req_t req,         // Instruction and operand
   input  wire logic                  opcode_fetch, // Opcode fetch strobe
   input  wire logic                  wake,        // Leave sleep
   input  wire logic                  bus_ack,     // Bus cycle complete
   input  wire logic [7:0]            bus_rdata,   // Read data from bus
   output logic                       busy,        // Instruction running
   output logic                       sleeping,    // Sleep state
   output ext_cpu_pkg::bus_req_t      bus,         // Bus request
   output logic [7:0]                 acc,         // Accumulator
   output logic [7:0]                 flags,       // Flag register
   output logic [15:0]                counter_pair,
   output logic [15:0]                data_pair,
   output logic [15:0]                memory_pointer_pair,
   output logic [15:0]                stack_pointer,
   output logic [15:0]                program_counter,
   output logic [15:0]                index_reg_first,
   output logic [15:0]                index_reg_second,
   output logic [7:0]                 int_vector,
   output logic [7:0]                 refresh_count
);
   import ext_cpu_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   // Flags of a logical AND result
   function automatic logic [7:0] and_flags(input logic [7:0] r);
      logic [7:0] f;
      f = 8'h00;
      f[FLAG_SIGN]     = r[7];
      f[FLAG_ZERO]     = (r == 8'h00);
      f[FLAG_HALF]     = 1'b1;
      f[FLAG_PARITY]   = ~(^r);
      f[FLAG_SUBTRACT] = 1'b0;
      f[FLAG_CARRY]    = 1'b0;
      return f;
   endfunction

   // Pick an 8-bit register by its three-bit code
   function automatic logic [7:0] pick8(input logic [2:0] s,
      input logic [15:0] bc, input logic [15:0] de,
      input logic [15:0] hl, input logic [7:0] a);
      logic [7:0] v;
      v = a;
      case (s)
         3'h0: v = bc[15:8];
         3'h1: v = bc[7:0];
         3'h2: v = de[15:8];
         3'h3: v = de[7:0];
         3'h4: v = hl[15:8];
         3'h5: v = hl[7:0];
         default: v = a;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   exec_state_t state_q;                       // Sequencer state
   ext_req_t    cur_q;                         // Latched instruction
   logic [7:0]  a_q, f_q, alt_a_q, alt_f_q;
   logic [15:0] bc_q, de_q, hl_q;
   logic [15:0] alt_bc_q, alt_de_q, alt_hl_q;
   logic [15:0] sp_q, pc_q, ix_q, iy_q;
   logic [7:0]  iv_q, rc_q;
   logic [7:0]  data_q;                        // Byte read from memory or a port
   bus_req_t    bus_q;                         // Registered bus request

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic        is_block = (cur_q.op == OP_OUT_INC) ||
                                (cur_q.op == OP_OUT_INC_RP) ||
                                (cur_q.op == OP_OUT_DEC) ||
                                (cur_q.op == OP_OUT_DEC_RP);
   wire logic        is_rep   = (cur_q.op == OP_OUT_INC_RP) ||
                                (cur_q.op == OP_OUT_DEC_RP);
   wire logic        is_inc   = (cur_q.op == OP_OUT_INC) ||
                                (cur_q.op == OP_OUT_INC_RP);
   wire logic [7:0]  reg_val  = pick8(cur_q.reg_sel, bc_q, de_q, hl_q, a_q);
   wire logic [15:0] pair_val = (cur_q.pair == PAIR_COUNTER) ? bc_q :
                                (cur_q.pair == PAIR_DATA)    ? de_q :
                                (cur_q.pair == PAIR_MEMPTR)  ? hl_q : sp_q;
   // halves of the chosen pair are the operands
   wire logic [15:0] product  = 16'(pair_val[15:8] * pair_val[7:0]);
   wire logic [7:0]  cnt_next = bc_q[15:8] - 8'h01;
   wire logic [15:0] step     = is_inc ? 16'h0001 : 16'hffff;
   wire logic [15:0] hl_step  = hl_q + step;
   wire logic [7:0]  port_step = bc_q[7:0] + step[7:0];
   wire logic        start    = (state_q == ST_IDLE) && req_valid;
   wire logic        need_mem = (req.op == OP_OUT_INC) ||
                                (req.op == OP_OUT_INC_RP) ||
                                (req.op == OP_OUT_DEC) ||
                                (req.op == OP_OUT_DEC_RP) ||
                                (req.op == OP_TEST_MEM);
   wire logic        need_io  = (req.op == OP_PORT_TEST) ||
                                (req.op == OP_PORT_IN) ||
                                (req.op == OP_PORT_OUT);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and register file
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q  <= ST_IDLE;
         cur_q    <= '0;
         a_q      <= 8'h00;
         f_q      <= 8'h00;
         alt_a_q  <= 8'h00;
         alt_f_q  <= 8'h00;
         bc_q     <= 16'h0000;
         de_q     <= 16'h0000;
         hl_q     <= 16'h0000;
         alt_bc_q <= 16'h0000;
         alt_de_q <= 16'h0000;
         alt_hl_q <= 16'h0000;
         sp_q     <= SP_RESET;
         pc_q     <= PC_RESET;
         ix_q     <= 16'h0000;
         iy_q     <= 16'h0000;
         iv_q     <= IV_RESET;
         rc_q     <= RC_RESET;
         data_q   <= 8'h00;
         bus_q    <= '0;
      end else if (clk_en) begin
         // Refresh counter: low seven bits only, bit 7 held
         if (opcode_fetch) begin
            rc_q <= {rc_q[7], 7'(rc_q[6:0] + 7'h01)};
         end
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  cur_q <= req;
                  if (req.op == OP_SLEEP) begin
                     state_q <= ST_SLEEP;
                  end else if (need_mem) begin
                     bus_q <= '{addr: hl_q, wdata: 8'h00, mem_rd: 1'b1,
                                io_rd: 1'b0, io_wr: 1'b0};
                     state_q <= ST_MEMRD;
                  end else if (need_io) begin
                     // upper address byte forced to zero
                     bus_q <= '{addr: {PORT_HIGH,
                                (req.op == OP_PORT_TEST) ? bc_q[7:0]
                                                          : req.operand},
                                wdata: pick8(req.reg_sel, bc_q, de_q,
                                             hl_q, a_q),
                                mem_rd: 1'b0,
                                io_rd: (req.op != OP_PORT_OUT),
                                io_wr: (req.op == OP_PORT_OUT)};
                     state_q <= ST_IOACC;
                  end else begin
                     state_q <= ST_FINISH;
                  end
               end
            end
            ST_MEMRD: begin
               if (bus_ack) begin
                  data_q       <= bus_rdata;
                  bus_q.mem_rd <= 1'b0;
                  if (is_block) begin
                     // memory byte to port at counter low half
                     bus_q <= '{addr: {PORT_HIGH, bc_q[7:0]},
                                wdata: bus_rdata, mem_rd: 1'b0,
                                io_rd: 1'b0, io_wr: 1'b1};
                     state_q <= ST_IOACC;
                  end else begin
                     state_q <= ST_FINISH;
                  end
               end
            end
            ST_IOACC: begin
               if (bus_ack) begin
                  data_q <= bus_rdata;
                  bus_q  <= '0;
                  if (is_block) begin
                     hl_q <= hl_step;
                     bc_q <= {cnt_next, port_step};
                     f_q[FLAG_ZERO]     <= (cnt_next == 8'h00);
                     f_q[FLAG_SUBTRACT] <= 1'b1;
                     if (is_rep && (cnt_next != 8'h00)) begin
                        bus_q <= '{addr: hl_step, wdata: 8'h00,
                                   mem_rd: 1'b1, io_rd: 1'b0, io_wr: 1'b0};
                        state_q <= ST_MEMRD;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     state_q <= ST_FINISH;
                  end
               end
            end
            ST_FINISH: begin
               state_q <= ST_IDLE;
               unique case (cur_q.op)
                  OP_MULTIPLY: begin
                     unique case (cur_q.pair)
                        PAIR_COUNTER: bc_q <= product;
                        PAIR_DATA:    de_q <= product;
                        PAIR_MEMPTR:  hl_q <= product;
                        PAIR_STACK:   sp_q <= product;
                     endcase
                  end
                  // port byte with immediate, flags only
                  OP_PORT_TEST: f_q <= and_flags(data_q & cur_q.operand);
                  OP_TEST_REG:  f_q <= and_flags(reg_val & a_q);
                  OP_TEST_IMM:  f_q <= and_flags(cur_q.operand & a_q);
                  OP_TEST_MEM:  f_q <= and_flags(data_q & a_q);
                  OP_PORT_IN: begin
                     case (cur_q.reg_sel)
                        3'h0: bc_q[15:8] <= data_q;
                        3'h1: bc_q[7:0]  <= data_q;
                        3'h2: de_q[15:8] <= data_q;
                        3'h3: de_q[7:0]  <= data_q;
                        3'h4: hl_q[15:8] <= data_q;
                        3'h5: hl_q[7:0]  <= data_q;
                        default: a_q <= data_q;
                     endcase
                  end
                  OP_EXCHANGE: begin
                     a_q <= alt_a_q;   alt_a_q  <= a_q;
                     f_q <= alt_f_q;   alt_f_q  <= f_q;
                     bc_q <= alt_bc_q; alt_bc_q <= bc_q;
                     de_q <= alt_de_q; alt_de_q <= de_q;
                     hl_q <= alt_hl_q; alt_hl_q <= hl_q;
                  end
                  default: ;
               endcase
            end
            ST_SLEEP: begin
               if (wake) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops; busy and sleeping decoded from state_q
   assign busy                = (state_q != ST_IDLE);
   assign sleeping            = (state_q == ST_SLEEP);
   assign bus                 = bus_q;
   assign acc                 = a_q;
   assign flags               = f_q;
   assign counter_pair        = bc_q;
   assign data_pair           = de_q;
   assign memory_pointer_pair = hl_q;
   assign stack_pointer       = sp_q;
   assign program_counter     = pc_q;
   assign index_reg_first     = ix_q;
   assign index_reg_second    = iy_q;
   assign int_vector          = iv_q;
   assign refresh_count       = rc_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   sleep_entry_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && start && req.op == OP_SLEEP) |=> sleeping)
      else $error("sleep not entered");
   mult_result_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && state_q == ST_FINISH && cur_q.op == OP_MULTIPLY &&
       cur_q.pair == PAIR_DATA) |=>
      de_q == 16'($past(de_q[15:8]) * $past(de_q[7:0])))
      else $error("multiply product wrong");
   port_high_a: assert property (@(posedge clk) disable iff (reset)
      (bus_q.io_rd || bus_q.io_wr) |-> bus_q.addr[15:8] == 8'h00)
      else $error("upper port address not zero");
   test_nowrite_a: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_IOACC && cur_q.op == OP_PORT_TEST) |-> !bus_q.io_wr)
      else $error("port test wrote port");
   test_keep_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && state_q == ST_FINISH && (cur_q.op == OP_TEST_REG ||
       cur_q.op == OP_TEST_IMM)) |=> $stable(a_q) && $stable(bc_q))
      else $error("test changed operand");
   test_flags_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && state_q == ST_FINISH && cur_q.op == OP_TEST_IMM) |=>
      f_q[FLAG_HALF] && !f_q[FLAG_CARRY] && !f_q[FLAG_SUBTRACT] &&
      f_q[FLAG_ZERO] == (($past(a_q) & $past(cur_q.operand)) == 8'h00))
      else $error("test flags wrong");
   block_step_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && state_q == ST_IOACC && is_block && bus_ack) |=>
      bc_q[15:8] == 8'($past(bc_q[15:8]) - 8'h01))
      else $error("block count not decremented");
   block_done_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && state_q == ST_IOACC && is_rep && bus_ack &&
       cnt_next == 8'h00) |=> state_q == ST_IDLE && f_q[FLAG_ZERO])
      else $error("repeat did not finish");
   refresh_a: assert property (@(posedge clk) disable iff (reset)
      (clk_en && opcode_fetch) |=>
      rc_q[6:0] == 7'($past(rc_q[6:0]) + 7'h01))
      else $error("refresh count not advanced");
endmodule // extended_cpu_instructions

// ### tb/bus_partner_model.sv
// Memory and I/O space responder with random wait cycles
`timescale 1ns/1ns
module bus_partner_model (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire ext_cpu_pkg::bus_req_t bus,
   output logic                       bus_ack,
   output logic [7:0]                 bus_rdata
);
   import ext_cpu_pkg::*;
   logic [7:0]  mem [256];     // Memory bytes by low address byte
   logic [7:0]  io_mem [256];  // Values returned by port reads
   logic [15:0] wr_addr [$];   // Port write address log
   logic [7:0]  wr_data [$];   // Port write data log
   int          hi_bad;        // Port cycles with nonzero upper byte
   int          wait_n;        // Wait cycles left for this cycle
   wire         active = bus.mem_rd | bus.io_rd | bus.io_wr;

   initial begin
      hi_bad = 0;
      wait_n = 0;
      bus_ack = 1'b0;
      bus_rdata = 8'h5a;
   end

   ////////////////////////////////////////////////////////////////////////
   // One acknowledge pulse per cycle; scrambled data outside of it
   always @(posedge clk) begin
      if (bus_ack || !active || reset) begin
         bus_ack <= 1'b0;
         bus_rdata <= ~bus_rdata;
         wait_n <= $urandom_range(2);
      end else if (wait_n > 0) begin
         wait_n <= wait_n - 1;
      end else begin
         bus_ack <= 1'b1;
         bus_rdata <= bus.mem_rd ? mem[bus.addr[7:0]] : io_mem[bus.addr[7:0]];
         // Port cycles must carry zero upper address
         if ((bus.io_rd || bus.io_wr) && bus.addr[15:8] != 8'h00) begin
            hi_bad <= hi_bad + 1;
         end
         // Record every port write
         if (bus.io_wr) begin
            wr_addr.push_back(bus.addr);
            wr_data.push_back(bus.wdata);
         end
      end
   end
endmodule // bus_partner_model

// ### tb/extended_cpu_instructions_tb_top.sv
// Self-checking bench for the extension instruction unit
`timescale 1ns/1ns
module extended_cpu_instructions_tb_top;
   import ext_cpu_pkg::*;
   logic clk, reset, clk_en, req_valid, opcode_fetch, wake, bus_ack;
   logic busy, sleeping;
   ext_req_t    req;           // Instruction request
   bus_req_t    bus;           // Bus request from the unit
   logic [7:0]  bus_rdata, acc, flags, int_vector, refresh_count;
   logic [15:0] counter_pair, data_pair, memory_pointer_pair;
   logic [15:0] stack_pointer, program_counter, idx_a, idx_b;
   int          errors = 0;    // Mismatch count
   int          compares = 0;  // Comparison count
   int          regs_m [8];    // Model registers by register select
   localparam logic [7:0] ZN = 8'h42; // Zero and subtract positions

   extended_cpu_instructions extended_cpu_instructions_inst (
      .clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
      .req(req), .opcode_fetch(opcode_fetch), .wake(wake),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy),
      .sleeping(sleeping), .bus(bus), .acc(acc), .flags(flags),
      .counter_pair(counter_pair), .data_pair(data_pair),
      .memory_pointer_pair(memory_pointer_pair),
      .stack_pointer(stack_pointer), .program_counter(program_counter),
      .index_reg_first(idx_a), .index_reg_second(idx_b),
      .int_vector(int_vector), .refresh_count(refresh_count));
   bus_partner_model bus_partner_model_inst (
      .clk(clk), .reset(reset), .bus(bus), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata));

   ////////////////////////////////////////////////////////////////////////
   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Issue one instruction and wait, bounded, for busy to drop
   task automatic do_op(input ext_op_t op, input pair_sel_t p,
                        input logic [2:0] rs, input logic [7:0] opnd);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op: op, pair: p, reg_sel: rs, operand: opnd};
      @(posedge clk);
      req_valid <= 1'b0;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         #1;
         if (busy === 1'b0) break;
      end
      if (n == 300) begin
         errors++;
         end_sim();
      end
   endtask

   // Load a register through a direct port read
   task automatic load(input int rs, input logic [7:0] v);
      bus_partner_model_inst.io_mem[8'h80 + rs] = v;
      regs_m[rs] = v;
      do_op(OP_PORT_IN, PAIR_COUNTER, 3'(rs), 8'(8'h80 + rs));
   endtask

   // Compare all general registers against the model
   task automatic check_all();
      check("acc", 16'(acc), 16'(regs_m[7]));
      check("counter", counter_pair, 16'(regs_m[0] * 256 + regs_m[1]));
      check("data", data_pair, 16'(regs_m[2] * 256 + regs_m[3]));
      check("memptr", memory_pointer_pair, 16'(regs_m[4] * 256 + regs_m[5]));
   endtask

   // Expected flags of an AND test result
   function automatic logic [7:0] test_flags(input logic [7:0] r);
      logic [7:0] f;
      f = 8'h00;
      f[FLAG_SIGN] = r[7];
      f[FLAG_ZERO] = (r == 8'h00);
      f[FLAG_HALF] = 1'b1;
      f[FLAG_PARITY] = ~^r;
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int i;
      int k;
      int p;
      logic [7:0] v;
      logic [7:0] r;
      void'($urandom(32'h11e7));
      reset <= 1'b1;
      clk_en <= 1'b1;
      req_valid <= 1'b0;
      req <= '0;
      opcode_fetch <= 1'b0;
      wake <= 1'b0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      // Reset state
      check("pc", program_counter, PC_RESET);
      check("sp", stack_pointer, SP_RESET);
      check("iv", 16'(int_vector), 16'(IV_RESET));
      check("busy", 16'(busy), 16'h0000);
      check("ix", idx_a, 16'h0000);
      check("iy", idx_b, 16'h0000);
      check("rc", 16'(refresh_count), 16'(RC_RESET));
      // Fetch pulses, one while frozen
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         opcode_fetch <= 1'b1;
         clk_en <= (i != 4);
      end
      @(posedge clk);
      opcode_fetch <= 1'b0;
      clk_en <= 1'b1;
      @(posedge clk);
      #1;
      check("refresh", 16'(refresh_count), 16'h0009);
      // Random register loads
      foreach (regs_m[j]) if (j != 6) load(j, 8'($urandom));
      check_all();
      // Multiply every pair
      for (k = 0; k < 4; k++) begin
         do_op(OP_MULTIPLY, pair_sel_t'(k), 3'h0, 8'h00);
         if (k < 3) begin
            p = regs_m[2 * k] * regs_m[2 * k + 1];
            regs_m[2 * k] = p / 256;
            regs_m[2 * k + 1] = p % 256;
         end
      end
      check_all();
      check("sp", stack_pointer, 16'h0000);
      // Register, immediate and memory AND tests
      for (i = 0; i < 6; i++) begin
         load(7, 8'($urandom));
         load(2, 8'($urandom));
         v = (i == 1) ? 8'h00 : 8'($urandom);
         bus_partner_model_inst.mem[regs_m[5]] = v;
         r = (i % 3 == 2) ? v : ((i % 3 == 1) ? v : 8'(regs_m[2]));
         r = r & 8'(regs_m[7]);
         do_op(ext_op_t'(OP_TEST_REG + i % 3), PAIR_COUNTER, 3'h2, v);
         check("tflags", 16'(flags & 8'hd7), 16'(test_flags(r)));
         check_all();
      end
      // Port AND test must not write
      v = 8'($urandom);
      bus_partner_model_inst.io_mem[regs_m[1]] = 8'($urandom);
      r = v & bus_partner_model_inst.io_mem[regs_m[1]];
      p = bus_partner_model_inst.wr_addr.size();
      do_op(OP_PORT_TEST, PAIR_COUNTER, 3'h0, v);
      check("pflags", 16'(flags & 8'hd7), 16'(test_flags(r)));
      check("writes", 16'(bus_partner_model_inst.wr_addr.size()), 16'(p));
      // Direct output of the accumulator
      do_op(OP_PORT_OUT, PAIR_COUNTER, 3'h7, 8'h55);
      check("oaddr", bus_partner_model_inst.wr_addr.pop_back(), 16'h0055);
      check("odata", 16'(bus_partner_model_inst.wr_data.pop_back()),
            16'(regs_m[7]));
      // Repeating block output, count three
      load(0, 8'h03);
      load(1, 8'h40);
      load(4, 8'h10);
      load(5, 8'h20);
      for (i = 0; i < 4; i++) bus_partner_model_inst.mem[8'h20 + i] = 8'($urandom);
      bus_partner_model_inst.wr_addr.delete();
      bus_partner_model_inst.wr_data.delete();
      do_op(OP_OUT_INC_RP, PAIR_COUNTER, 3'h0, 8'h00);
      check("count", 16'(bus_partner_model_inst.wr_addr.size()), 16'h0003);
      for (i = 0; i < 3; i++) begin
         check("baddr", bus_partner_model_inst.wr_addr[i], 16'(8'h40 + i));
         check("bdata", 16'(bus_partner_model_inst.wr_data[i]),
               16'(bus_partner_model_inst.mem[8'h20 + i]));
      end
      regs_m[0] = 0;
      regs_m[1] = 8'h43;
      regs_m[5] = 8'h23;
      check_all();
      check("rflags", 16'(flags & ZN), 16'(ZN));
      // Single decrementing step, count two
      load(0, 8'h02);
      bus_partner_model_inst.wr_addr.delete();
      bus_partner_model_inst.wr_data.delete();
      do_op(OP_OUT_DEC, PAIR_COUNTER, 3'h0, 8'h00);
      check("dcount", 16'(bus_partner_model_inst.wr_addr.size()), 16'h0001);
      check("daddr", bus_partner_model_inst.wr_addr[0], 16'h0043);
      check("ddata", 16'(bus_partner_model_inst.wr_data[0]),
            16'(bus_partner_model_inst.mem[8'h23]));
      regs_m[0] = 1;
      regs_m[1] = 8'h42;
      regs_m[5] = 8'h22;
      check_all();
      check("dflags", 16'(flags & ZN), 16'h0002);
      // Repeating decrement, count two, then a lone increment step
      load(0, 8'h02);
      bus_partner_model_inst.wr_addr.delete();
      bus_partner_model_inst.wr_data.delete();
      do_op(OP_OUT_DEC_RP, PAIR_COUNTER, 3'h0, 8'h00);
      check("rdcount", 16'(bus_partner_model_inst.wr_addr.size()),
            16'h0002);
      for (i = 0; i < 2; i++) begin
         check("rdaddr", bus_partner_model_inst.wr_addr[i],
               16'(8'h42 - i));
         check("rddata", 16'(bus_partner_model_inst.wr_data[i]),
               16'(bus_partner_model_inst.mem[8'h22 - i]));
      end
      regs_m[0] = 0;
      regs_m[1] = 8'h40;
      regs_m[5] = 8'h20;
      check_all();
      check("rdflags", 16'(flags & ZN), 16'(ZN));
      do_op(OP_OUT_INC, PAIR_COUNTER, 3'h0, 8'h00);
      check("icount", 16'(bus_partner_model_inst.wr_addr.size()),
            16'h0003);
      check("iaddr", bus_partner_model_inst.wr_addr[2],
            16'h0040);
      check("idata", 16'(bus_partner_model_inst.wr_data[2]),
            16'(bus_partner_model_inst.mem[8'h20]));
      regs_m[0] = 8'hff;
      regs_m[1] = 8'h41;
      regs_m[5] = 8'h21;
      check_all();
      check("iflags", 16'(flags & ZN), 16'h0002);
      // Swap to the cleared alternate set and back
      do_op(OP_EXCHANGE, PAIR_COUNTER, 3'h0, 8'h00);
      check("xacc", 16'(acc), 16'h0000);
      check("xcnt", counter_pair, 16'h0000);
      do_op(OP_EXCHANGE, PAIR_COUNTER, 3'h0, 8'h00);
      check_all();
      // Sleep holds until wake
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op: OP_SLEEP, pair: PAIR_COUNTER, reg_sel: 3'h0, operand: 8'h00};
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check("sleep", 16'(sleeping), 16'h0001);
      @(posedge clk);
      wake <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         if (sleeping === 1'b0 && busy === 1'b0) break;
      end
      wake <= 1'b0;
      check("awake", 16'(sleeping), 16'h0000);
      check("hibyte", 16'(bus_partner_model_inst.hi_bad), 16'h0000);
      end_sim();
   end
endmodule // extended_cpu_instructions_tb_top
